/* File: shared/dcc_pkg.sv */
// Package for the dual comparator control block: addresses, fields, reset values.
package dcc_pkg;

   localparam logic [7:0] ADDR_B_CONTROL = 8'h9A;
   localparam logic [7:0] ADDR_A_CONTROL = 8'h9B;
   localparam logic [7:0] ADDR_B_MODE    = 8'h9C;
   localparam logic [7:0] ADDR_A_MODE    = 8'h9D;

   localparam int CTL_ON_BIT    = 7;
   localparam int CTL_STATE_BIT = 6;
   localparam int CTL_RISE_BIT  = 5;
   localparam int CTL_FALL_BIT  = 4;
   localparam int CTL_HYP_LSB   = 2;
   localparam int CTL_HYN_LSB   = 0;

   localparam int MD_RISE_IE_BIT = 5;
   localparam int MD_FALL_IE_BIT = 4;
   localparam int MD_SPEED_LSB   = 0;

   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET    = 8'h02;
   localparam logic [7:0] MODE_WR_MASK  = 8'h33;

   localparam int SYNC_STAGES = 2;

   // Hysteresis amount seen by the analog core, one-hot by step size.
   typedef enum logic [3:0] {
      DCC_HYST_OFF  = 4'h0,
      DCC_HYST_5MV  = 4'h1,
      DCC_HYST_10MV = 4'h2,
      DCC_HYST_20MV = 4'h4
   } dcc_hyst_t;

endpackage : dcc_pkg

/* File: design/dcc_channel.sv */
// One comparator channel: control and mode registers, synchroniser, flags, interrupt.
`timescale 1ns/1ps

module dcc_channel #(
   parameter logic [7:0] CTL_ADDR = 8'h9B,  // control register address
   parameter logic [7:0] MD_ADDR  = 8'h9D   // mode register address
) (
   input  wire logic       clk,           // system clock
   input  wire logic       rst_b,         // asynchronous reset, active low
   input  wire logic       wr_en,         // register write strobe
   input  wire logic [7:0] addr,          // register address
   input  wire logic [7:0] wdata,         // write data
   input  wire logic       raw_in,        // raw comparator result from analog core
   output logic      [7:0] ctl_q,         // control register readback
   output logic      [7:0] md_q,          // mode register readback
   output logic            latched_q,     // synchronised gated output
   output logic            irq_q          // interrupt request
);

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] ctl;
   logic [7:0] md;
   logic [dcc_pkg::SYNC_STAGES-1:0] sync;
   logic       prev;
   logic [7:0] next_ctl;
   logic [7:0] next_md;
   logic       next_prev;
   logic       next_irq;
   logic       rise_ev;
   logic       fall_ev;
   logic       cur;

   always_comb begin
      cur     = sync[dcc_pkg::SYNC_STAGES-1];
      rise_ev = ctl[dcc_pkg::CTL_ON_BIT] && cur && !prev;
      fall_ev = ctl[dcc_pkg::CTL_ON_BIT] && !cur && prev;
      next_prev = cur;
      next_ctl  = ctl;
      next_md   = md;
      if (wr_en && addr == CTL_ADDR) begin
         next_ctl = wdata;
      end
      if (wr_en && addr == MD_ADDR) begin
         next_md = wdata & dcc_pkg::MODE_WR_MASK;
      end
      // The state bit is a mirror of the synchronised result, not storage.
      next_ctl[dcc_pkg::CTL_STATE_BIT] = cur;
      // Hardware edges win over a software clear in the same cycle.
      if (rise_ev) begin
         next_ctl[dcc_pkg::CTL_RISE_BIT] = 1'b1;
      end
      if (fall_ev) begin
         next_ctl[dcc_pkg::CTL_FALL_BIT] = 1'b1;
      end
      next_irq = (next_ctl[dcc_pkg::CTL_RISE_BIT] && next_md[dcc_pkg::MD_RISE_IE_BIT])
              || (next_ctl[dcc_pkg::CTL_FALL_BIT] && next_md[dcc_pkg::MD_FALL_IE_BIT]);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl       <= dcc_pkg::CONTROL_RESET;
         md        <= dcc_pkg::MODE_RESET;
         sync      <= '0;
         prev      <= 1'b0;
         latched_q <= 1'b0;
         irq_q     <= 1'b0;
      end else begin
         ctl       <= next_ctl;
         md        <= next_md;
         sync      <= {sync[dcc_pkg::SYNC_STAGES-2:0], raw_in};
         prev      <= next_prev;
         latched_q <= cur && ctl[dcc_pkg::CTL_ON_BIT];
         irq_q     <= next_irq;
      end
   end

   assign ctl_q = ctl;
   assign md_q  = md;

endmodule : dcc_channel

/* File: design/dcc_top.sv */
// Top of the dual comparator control block: register port and two channels.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Two channels with identical control logic; only addresses, inputs and reset use differ.
// - Channel A result is offered as a reset source, gated elsewhere.
// - Each channel offers a clocked latched output and a raw unclocked output.
// - Raw output follows the comparator with no clock involved.
// - Disabled channel forces its pin output low and powers down its core.
// - Mode bits 1:0 drive speed select; 00 fastest, 11 slowest.
// - Control bits 3:2 select positive hysteresis off, 5, 10 or 20 mV.
// - Control bits 1:0 select negative hysteresis off, 5, 10 or 20 mV.
// - Falling result sets control bit 4.
// - Rising result sets control bit 5.
// - Edge flags are sticky; only a software write of zero clears them.
// - Interrupt request from either edge, each gated by its own enable.
// - Mode bit 5 enables the rising-edge interrupt.
// - Mode bit 4 enables the falling-edge interrupt.
// - Control bit 6 reads the current result, read only.
// - Control bit 7 turns the channel on or off.
// - Mode bits 7:6 and 3:2 read zero and ignore writes.
// - Channel A control register at 0x9B on every page.
// - Channel A mode register at 0x9D on every page.
// - Channel B control register at 0x9A, same layout.
// - Channel B mode register at 0x9C, same layout.
module dcc_top (
   input  wire logic       clk,              // system clock
   input  wire logic       rst_b,            // asynchronous reset, active low
   input  wire logic       sfr_wr,           // register write strobe
   input  wire logic       sfr_rd,           // register read strobe
   input  wire logic [7:0] sfr_addr,         // register address
   input  wire logic [7:0] sfr_wdata,        // write data
   output logic      [7:0] sfr_rdata,        // read data, valid cycle after sfr_rd
   output logic            sfr_hit,          // read hit one of the four registers
   input  wire logic       cmp_a_result,     // analog result, channel A
   input  wire logic       cmp_b_result,     // analog result, channel B
   output logic            cmp_a_latched_out,// synchronised output A
   output logic            cmp_b_latched_out,// synchronised output B
   output logic            cmp_a_raw_out,    // raw output A
   output logic            cmp_b_raw_out,    // raw output B
   output logic            cmp_a_reset_src,  // channel A reset source candidate
   output logic            cmp_a_power_down, // analog power down A
   output logic            cmp_b_power_down, // analog power down B
   output logic      [1:0] cmp_a_speed_sel,  // response speed select A
   output logic      [1:0] cmp_b_speed_sel,  // response speed select B
   output logic      [3:0] cmp_a_pos_hyst,   // decoded positive hysteresis A
   output logic      [3:0] cmp_a_neg_hyst,   // decoded negative hysteresis A
   output logic      [3:0] cmp_b_pos_hyst,   // decoded positive hysteresis B
   output logic      [3:0] cmp_b_neg_hyst,   // decoded negative hysteresis B
   output logic            cmp_irq           // comparator interrupt request
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] hyst_decode(input logic [1:0] code);
      dcc_pkg::dcc_hyst_t h;
      case (code)
         2'h0:    h = dcc_pkg::DCC_HYST_OFF;
         2'h1:    h = dcc_pkg::DCC_HYST_5MV;
         2'h2:    h = dcc_pkg::DCC_HYST_10MV;
         default: h = dcc_pkg::DCC_HYST_20MV;
      endcase
      return h;
   endfunction : hyst_decode

   logic [7:0] a_ctl, a_md, b_ctl, b_md;
   logic       a_lat, b_lat, a_irq, b_irq;
   logic [7:0] next_rdata;
   logic       next_hit;

   dcc_channel #(
      .CTL_ADDR (dcc_pkg::ADDR_A_CONTROL),
      .MD_ADDR  (dcc_pkg::ADDR_A_MODE)
   ) u_chan_a (
      .clk       (clk),
      .rst_b     (rst_b),
      .wr_en     (sfr_wr),
      .addr      (sfr_addr),
      .wdata     (sfr_wdata),
      .raw_in    (cmp_a_result),
      .ctl_q     (a_ctl),
      .md_q      (a_md),
      .latched_q (a_lat),
      .irq_q     (a_irq)
   );

   dcc_channel #(
      .CTL_ADDR (dcc_pkg::ADDR_B_CONTROL),
      .MD_ADDR  (dcc_pkg::ADDR_B_MODE)
   ) u_chan_b (
      .clk       (clk),
      .rst_b     (rst_b),
      .wr_en     (sfr_wr),
      .addr      (sfr_addr),
      .wdata     (sfr_wdata),
      .raw_in    (cmp_b_result),
      .ctl_q     (b_ctl),
      .md_q      (b_md),
      .latched_q (b_lat),
      .irq_q     (b_irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_hit = 1'b1;
      case (sfr_addr)
         dcc_pkg::ADDR_A_CONTROL: next_rdata = a_ctl;
         dcc_pkg::ADDR_A_MODE:    next_rdata = a_md;
         dcc_pkg::ADDR_B_CONTROL: next_rdata = b_ctl;
         dcc_pkg::ADDR_B_MODE:    next_rdata = b_md;
         default: begin
            next_rdata = 8'h00;
            next_hit   = 1'b0;
         end
      endcase
      if (!sfr_rd) begin
         next_hit = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata <= 8'h00;
         sfr_hit   <= 1'b0;
      end else begin
         sfr_rdata <= next_rdata;
         sfr_hit   <= next_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The raw paths must work with the clock stopped, so they are gated by the
   // enable flops only and never pass through a clocked stage.
   assign cmp_a_raw_out   = cmp_a_result && a_ctl[dcc_pkg::CTL_ON_BIT];
   assign cmp_b_raw_out   = cmp_b_result && b_ctl[dcc_pkg::CTL_ON_BIT];
   assign cmp_a_reset_src = cmp_a_raw_out;
   assign cmp_a_latched_out = a_lat;
   assign cmp_b_latched_out = b_lat;
   assign cmp_irq         = a_irq || b_irq;
   assign cmp_a_power_down = !a_ctl[dcc_pkg::CTL_ON_BIT];
   assign cmp_b_power_down = !b_ctl[dcc_pkg::CTL_ON_BIT];
   assign cmp_a_speed_sel = a_md[dcc_pkg::MD_SPEED_LSB +: 2];
   assign cmp_b_speed_sel = b_md[dcc_pkg::MD_SPEED_LSB +: 2];
   assign cmp_a_pos_hyst  = hyst_decode(a_ctl[dcc_pkg::CTL_HYP_LSB +: 2]);
   assign cmp_b_pos_hyst  = hyst_decode(b_ctl[dcc_pkg::CTL_HYP_LSB +: 2]);
   assign cmp_a_neg_hyst  = hyst_decode(a_ctl[dcc_pkg::CTL_HYN_LSB +: 2]);
   assign cmp_b_neg_hyst  = hyst_decode(b_ctl[dcc_pkg::CTL_HYN_LSB +: 2]);

endmodule : dcc_top

/* File: verif/dcc_core_model.sv */
// Behavioural analog comparator core for one channel.
`timescale 1ns/1ps
module dcc_core_model (
   input  wire logic clk,        // system clock
   input  wire logic power_down, // core power down
   input  wire logic level,      // wanted input sign
   output logic      result      // comparator result
);
   logic wobble;
   // An unpowered core has no defined answer, so it shows a level that changes every cycle.
   initial wobble = 1'b0;
   always @(posedge clk) wobble <= ~wobble;
   assign result = power_down ? wobble : level;
endmodule : dcc_core_model

/* File: verif/dcc_chk.sv */
// Concurrent checks on the ports of the dual comparator control block.
`timescale 1ns/1ps
module dcc_chk (
   input wire logic       clk,               // clock
   input wire logic       rst_b,             // reset
   input wire logic       sfr_wr,            // write
   input wire logic       sfr_rd,            // read
   input wire logic [7:0] sfr_addr,          // address
   input wire logic [7:0] sfr_wdata,         // write data
   input wire logic [7:0] sfr_rdata,         // read data
   input wire logic       sfr_hit,           // hit
   input wire logic       cmp_a_result,      // result A
   input wire logic       cmp_a_latched_out, // latched A
   input wire logic       cmp_a_raw_out,     // raw A
   input wire logic       cmp_a_reset_src,   // reset source A
   input wire logic       cmp_a_power_down,  // power down A
   input wire logic [1:0] cmp_a_speed_sel,   // speed A
   input wire logic [3:0] cmp_a_pos_hyst,    // hysteresis A
   input wire logic       cmp_irq            // interrupt
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire in_map = sfr_addr >= 8'h9A && sfr_addr <= 8'h9D;
   raw_gate_a: assert property (cmp_a_raw_out == (cmp_a_result && !cmp_a_power_down))
      else $error("raw output does not follow gated result");
   reset_src_a: assert property (cmp_a_reset_src == cmp_a_raw_out)
      else $error("reset source differs from raw output");
   latch_off_a: assert property ($past(cmp_a_power_down) && cmp_a_power_down |-> !cmp_a_latched_out)
      else $error("latched output high while disabled");
   speed_follow_a: assert property (sfr_wr && sfr_addr == 8'h9D |=> cmp_a_speed_sel == $past(sfr_wdata[1:0]))
      else $error("speed select does not follow mode write");
   hyst_decode_a: assert property (sfr_wr && sfr_addr == 8'h9B |=> cmp_a_pos_hyst == (4'h1 << $past(sfr_wdata[3:2])) >> 1)
      else $error("positive hysteresis decode wrong");
   read_map_a: assert property (sfr_rd |=> sfr_hit == $past(in_map) && (sfr_hit || sfr_rdata == 8'h00))
      else $error("read hit or unmapped data wrong");
   mode_unused_a: assert property (sfr_rd && sfr_addr[7:1] == 7'h4E |=> sfr_rdata[7:6] == 2'b00 && sfr_rdata[3:2] == 2'b00)
      else $error("unused mode bits read nonzero");
   irq_sticky_a: assert property (cmp_irq && !sfr_wr |=> cmp_irq)
      else $error("interrupt dropped without a write");
endmodule : dcc_chk
bind dcc_top dcc_chk u_dcc_chk (.clk(clk), .rst_b(rst_b), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
   .cmp_a_result(cmp_a_result), .cmp_a_latched_out(cmp_a_latched_out),
   .cmp_a_raw_out(cmp_a_raw_out), .cmp_a_reset_src(cmp_a_reset_src),
   .cmp_a_power_down(cmp_a_power_down), .cmp_a_speed_sel(cmp_a_speed_sel),
   .cmp_a_pos_hyst(cmp_a_pos_hyst), .cmp_irq(cmp_irq));

/* File: verif/dcc_top_tb_top.sv */
// Self-checking testbench for the dual comparator control block.
`timescale 1ns/1ps
module dcc_top_tb_top;
   logic       clk, rst_b, sfr_wr, sfr_rd, lvl_a, lvl_b, sfr_hit, res_a, res_b;
   logic       lat_a, lat_b, raw_a, raw_b, pd_a, pd_b, irq;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [1:0] spd_a, spd_b;
   logic [3:0] hp_a, hn_a, hp_b, hn_b;
   int         mismatches, checks_done;
   dcc_top u_dcc_top (.clk(clk), .rst_b(rst_b), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .cmp_a_result(res_a), .cmp_b_result(res_b), .cmp_a_latched_out(lat_a),
      .cmp_b_latched_out(lat_b), .cmp_a_raw_out(raw_a), .cmp_b_raw_out(raw_b),
      .cmp_a_reset_src(), .cmp_a_power_down(pd_a), .cmp_b_power_down(pd_b),
      .cmp_a_speed_sel(spd_a), .cmp_b_speed_sel(spd_b), .cmp_a_pos_hyst(hp_a),
      .cmp_a_neg_hyst(hn_a), .cmp_b_pos_hyst(hp_b), .cmp_b_neg_hyst(hn_b), .cmp_irq(irq));
   dcc_core_model u_dcc_core_model (.clk(clk), .power_down(pd_a), .level(lvl_a), .result(res_a));
   dcc_core_model u_dcc_core_model_b (.clk(clk), .power_down(pd_b), .level(lvl_b), .result(res_b));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
      sfr_wr <= 1'b0;
      #1;
   endtask : wr
   // The mask hides the result bit while the core is unpowered and its level is undefined.
   task automatic rd(input logic [7:0] a, input logic [8:0] exp, input logic [7:0] m);
      @(posedge clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1;
      chk({sfr_hit, sfr_rdata & m}, exp & {1'b1, m}, "read");
   endtask : rd
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step
   task automatic results();
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      step(3000);
      mismatches++;
      results();
   end
   initial begin
      {rst_b, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, lvl_a, lvl_b} = '0;
      mismatches = 0;
      checks_done = 0;
      step(8);
      rst_b <= 1'b1;
      rd(8'h9B, 9'h100, 8'hBF);
      rd(8'h9D, 9'h102, 8'hFF);
      rd(8'h9A, 9'h100, 8'hBF);
      rd(8'h9C, 9'h102, 8'hFF);
      rd(8'h9E, 9'h000, 8'hFF);
      chk({7'h00, pd_a, pd_b}, 9'h003, "power_down");
      wr(8'h9D, 8'hFF);
      wr(8'h9C, 8'hFF);
      rd(8'h9D, 9'h133, 8'hFF);
      rd(8'h9C, 9'h133, 8'hFF);
      for (int v = 0; v < 4; v++) begin
         wr(8'h9D, 8'(v));
         chk({7'h00, spd_a}, 9'(v), "speed");
         wr(8'h9B, 8'(v * 5));
         chk({1'b0, hp_a, hn_a}, {1'b0, (4'h1 << v) >> 1, (4'h1 << v) >> 1}, "hyst");
         // Channel B walks the codes in the opposite order so a crossed channel shows up.
         wr(8'h9C, 8'(3 - v));
         chk({7'h00, spd_b}, 9'(3 - v), "speed b");
         wr(8'h9A, 8'((3 - v) * 5));
         chk({1'b0, hp_b, hn_b}, {1'b0, (4'h1 << (3 - v)) >> 1, (4'h1 << (3 - v)) >> 1}, "hyst b");
      end
      wr(8'h9B, 8'h80);
      chk({8'h00, pd_a}, 9'h000, "power_down");
      step(4);
      wr(8'h9B, 8'h80);
      wr(8'h9D, 8'h30);
      lvl_a <= 1'b1;
      step(5);
      #1;
      chk({6'h00, irq, lat_a, raw_a}, 9'h007, "a rise");
      rd(8'h9B, 9'h1E0, 8'hFF);
      lvl_a <= 1'b0;
      step(5);
      rd(8'h9B, 9'h1B0, 8'hFF);
      wr(8'h9B, 8'h80);
      chk({8'h00, irq}, 9'h000, "irq");
      wr(8'h9D, 8'h10);
      lvl_a <= 1'b1;
      step(5);
      #1;
      chk({8'h00, irq}, 9'h000, "irq");
      wr(8'h9D, 8'h20);
      chk({8'h00, irq}, 9'h001, "irq");
      wr(8'h9B, 8'h00);
      step(6);
      #1;
      chk({6'h00, lat_a, raw_a, pd_a}, 9'h001, "a off");
      rd(8'h9B, 9'h100, 8'hBF);
      chk({8'h00, irq}, 9'h000, "irq");
      wr(8'h9A, 8'h80);
      step(4);
      wr(8'h9A, 8'h80);
      wr(8'h9C, 8'h10);
      lvl_b <= 1'b1;
      step(5);
      lvl_b <= 1'b0;
      step(5);
      #1;
      chk({6'h00, irq, lat_b, raw_b}, 9'h004, "b fall");
      rd(8'h9A, 9'h1B0, 8'hFF);
      results();
   end
endmodule : dcc_top_tb_top
